// File: rtl/aip_irq_ctrl.sv
// interrupt aggregation, clipping status and pin control registers of the amplifier
// assumes one-cycle register read/write strobes from the control port decoder,
// event pulses from the rate converter and volume logic, and clip levels per channel

module aip_irq_ctrl
    import aip_pkg::*;
(
    // clock and reset
    input  wire logic               clock_in,
    input  wire logic               nrst_in,
    input  wire logic               ce_in,
    // register port
    input  aip_reg_req_s            req_in,
    output logic [DATA_W-1:0]       rdata_out,
    // event sources
    input  aip_events_s             events_in,
    input  wire logic [CH_CNT-1:0]  clip_in,
    // general-purpose pins
    input  wire logic [PIN_CNT-1:0] pin_in,
    output logic [PIN_CNT-1:0]      pin_out,
    output logic [PIN_CNT-1:0]      pin_oe_out,
    // interrupt pin
    output logic                    irq_out,
    output logic                    irq_oe_out
);

    // ------------------------------------------------------------------
    // decode helper
    // ------------------------------------------------------------------
    function automatic logic hit(input logic stb, input logic [7:0] a,
                                 input logic [7:0] ofs);
        return stb && (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    aip_state_s           state_reg;
    aip_state_s           state_next;
    logic [PIN_CNT-1:0]   pin_stat;
    logic                 rd_flags;
    logic                 rd_clip;
    logic                 rd_pins;
    logic                 wr_pins;
    logic                 clip_sum;
    logic                 pin_sum;
    logic [7:0]           flags_view;
    logic [7:0]           irq_enable;
    logic                 irq_active;
    logic [CH_CNT-1:0]    clip_clr;
    aip_style_e           style;

    localparam aip_state_s STATE_RST = '{
        mode:    RST_MODE,
        mask:    RST_MASK,
        dir:     RST_DIR,
        pol:     RST_POL,
        trig:    RST_TRIG,
        pmask:   RST_PMASK,
        flags:   '{default: 1'b0},
        clip:    '0,
        rdata:   8'h00,
        irq_drv: 1'b0,
        irq_oe:  1'b0
    };

    assign rd_flags = hit(req_in.rd, req_in.addr, OFS_IRQ_EVENT_FLAGS);
    assign rd_clip  = hit(req_in.rd, req_in.addr, OFS_CHANNEL_CLIP);
    assign rd_pins  = hit(req_in.rd, req_in.addr, OFS_PIN_STATE);
    assign wr_pins  = hit(req_in.wr, req_in.addr, OFS_PIN_STATE);

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi++) begin : g_pin
            aip_pin_cell u_pin (
                .clock_in    (clock_in),
                .nrst_in     (nrst_in),
                .ce_in       (ce_in),
                .dir_in      (state_reg.dir[gi]),
                .pol_type_in (state_reg.pol[gi]),
                .edge_sel_in (state_reg.trig[gi]),
                .wr_stb_in   (wr_pins),
                .wr_val_in   (req_in.wdata[gi]),
                .rd_clr_in   (rd_pins),
                .pin_in      (pin_in[gi]),
                .status_out  (pin_stat[gi]),
                .pin_out     (pin_out[gi]),
                .pin_oe_out  (pin_oe_out[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // summaries and interrupt level
    // ------------------------------------------------------------------
    always_comb begin
        clip_sum   = |state_reg.clip;
        // output pins never raise the pin summary
        pin_sum    = |(pin_stat[PIRQ_CNT-1:0] & state_reg.pmask[PIRQ_CNT-1:0]
                       & ~state_reg.dir[PIRQ_CNT-1:0]);
        flags_view = {state_reg.flags, clip_sum, pin_sum, 1'b0};
        irq_enable = {state_reg.mask[7:2], 1'b1, 1'b0};
        irq_active = |(flags_view & irq_enable);
        style      = aip_style_e'(state_reg.mode[STYLE_LSB +: 2]);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // configuration writes
        if (hit(req_in.wr, req_in.addr, OFS_IRQ_MODE_CTRL)) begin
            state_next.mode = req_in.wdata & WR_MODE_BITS;
        end
        if (hit(req_in.wr, req_in.addr, OFS_IRQ_SOURCE_MASK)) begin
            state_next.mask = req_in.wdata & WR_MASK_BITS;
        end
        if (hit(req_in.wr, req_in.addr, OFS_PIN_DIRECTION)) begin
            state_next.dir = req_in.wdata & WR_PIN_BITS;
        end
        if (hit(req_in.wr, req_in.addr, OFS_PIN_POL_TYPE)) begin
            state_next.pol = req_in.wdata & WR_PIN_BITS;
        end
        if (hit(req_in.wr, req_in.addr, OFS_PIN_TRIGGER)) begin
            state_next.trig = req_in.wdata & WR_PIN_BITS;
        end
        if (hit(req_in.wr, req_in.addr, OFS_PIN_IRQ_MASK)) begin
            state_next.pmask = req_in.wdata & WR_PMASK_BITS;
        end

        // edge flags: read clears, a same-cycle event still sets
        if (rd_flags) begin
            state_next.flags = '{default: 1'b0};
        end
        if (events_in.unlock) begin
            // unlock beats a simultaneous lock: the loss is the safer report
            state_next.flags.unlock = 1'b1;
            state_next.flags.lock   = 1'b0;
        end else if (events_in.lock) begin
            state_next.flags.lock   = 1'b1;
            state_next.flags.unlock = 1'b0;
        end
        state_next.flags.ramp_up   = state_next.flags.ramp_up   | events_in.ramp_up;
        state_next.flags.ramp_down = state_next.flags.ramp_down | events_in.ramp_down;
        state_next.flags.mute_done = state_next.flags.mute_done | events_in.mute_done;

        // clip bits: mask plays no part; level type keeps a bit while clipping
        if (!rd_clip) begin
            clip_clr = '0;
        end else if (state_reg.mode[CLIP_TRIG_BIT]) begin
            clip_clr = '1;
        end else begin
            clip_clr = ~clip_in;
        end
        state_next.clip = (state_reg.clip & ~clip_clr) | clip_in;

        // read data, captured before any clear takes effect
        state_next.rdata = 8'h00;
        if (req_in.rd) begin
            case (req_in.addr)
                OFS_IRQ_MODE_CTRL:   state_next.rdata = state_reg.mode;
                OFS_IRQ_SOURCE_MASK: state_next.rdata = state_reg.mask;
                OFS_IRQ_EVENT_FLAGS: state_next.rdata = flags_view;
                OFS_CHANNEL_CLIP:    state_next.rdata = {2'b00, state_reg.clip};
                OFS_PIN_DIRECTION:   state_next.rdata = state_reg.dir;
                OFS_PIN_POL_TYPE:    state_next.rdata = state_reg.pol;
                OFS_PIN_TRIGGER:     state_next.rdata = state_reg.trig;
                OFS_PIN_STATE:       state_next.rdata = {1'b0, pin_stat};
                OFS_PIN_IRQ_MASK:    state_next.rdata = state_reg.pmask;
                default:             state_next.rdata = 8'h00;
            endcase
        end

        // interrupt pin drive per style; reserved style releases the pin
        case (style)
            AIP_STYLE_HIGH: begin
                state_next.irq_drv = irq_active;
                state_next.irq_oe  = 1'b1;
            end
            AIP_STYLE_LOW: begin
                state_next.irq_drv = ~irq_active;
                state_next.irq_oe  = 1'b1;
            end
            AIP_STYLE_OD: begin
                state_next.irq_drv = 1'b0;
                state_next.irq_oe  = irq_active;
            end
            default: begin
                state_next.irq_drv = 1'b0;
                state_next.irq_oe  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_reg <= STATE_RST;
        end else if (ce_in) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_out  = state_reg.rdata;
    assign irq_out    = state_reg.irq_drv;
    assign irq_oe_out = state_reg.irq_oe;

endmodule

// File: rtl/aip_pin_cell.sv
// one general-purpose pin: input status capture and output drive
// assumes the pad input is synchronous to clock_in

module aip_pin_cell
    import aip_pkg::*;
(
    // clock and reset
    input  wire logic clock_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    // configuration
    input  wire logic dir_in,
    input  wire logic pol_type_in,
    input  wire logic edge_sel_in,
    // register strobes
    input  wire logic wr_stb_in,
    input  wire logic wr_val_in,
    input  wire logic rd_clr_in,
    // pad
    input  wire logic pin_in,
    output logic      status_out,
    output logic      pin_out,
    output logic      pin_oe_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    aip_pin_state_s state_reg;
    aip_pin_state_s state_next;
    logic           act;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        act        = pol_type_in ? pin_in : ~pin_in;
        state_next.prev_act = act;
        if (wr_stb_in) begin
            state_next.out_val = wr_val_in;
        end
        // a new edge in the read cycle survives the clear
        if (dir_in || !edge_sel_in) begin
            state_next.sticky = 1'b0;
        end else begin
            state_next.sticky = (state_reg.sticky & ~rd_clr_in)
                              | (act & ~state_reg.prev_act);
        end
        if (dir_in && pol_type_in) begin
            // open drain: only pull low
            state_next.drv = 1'b0;
            state_next.oe  = ~state_next.out_val;
        end else begin
            state_next.drv = state_next.out_val;
            state_next.oe  = dir_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_reg <= PIN_RST;
        end else if (ce_in) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_comb begin
        if (dir_in) begin
            status_out = state_reg.out_val;
        end else if (edge_sel_in) begin
            status_out = state_reg.sticky;
        end else begin
            // level pins show the live active level, never latched
            status_out = pol_type_in ? pin_in : ~pin_in;
        end
    end

    assign pin_out    = state_reg.drv;
    assign pin_oe_out = state_reg.oe;

endmodule

// File: rtl/aip_pkg.sv
// shared constants, types and register map of the amplifier interrupt and pin status block
// assumes a single 40 MHz system clock and a byte-wide register port in front of it

package aip_pkg;

    // ------------------------------------------------------------------
    // sizes and clock
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned CH_CNT   = 6;
    localparam int unsigned PIN_CNT  = 7;
    localparam int unsigned PIRQ_CNT = 4;
    localparam int unsigned CLK_HZ   = 40_000_000;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_MODE_CTRL   = 8'h28;
    localparam logic [7:0] OFS_IRQ_SOURCE_MASK = 8'h29;
    localparam logic [7:0] OFS_IRQ_EVENT_FLAGS = 8'h2a;
    localparam logic [7:0] OFS_CHANNEL_CLIP    = 8'h2b;
    localparam logic [7:0] OFS_PIN_DIRECTION   = 8'h2c;
    localparam logic [7:0] OFS_PIN_POL_TYPE    = 8'h2d;
    localparam logic [7:0] OFS_PIN_TRIGGER     = 8'h2e;
    localparam logic [7:0] OFS_PIN_STATE       = 8'h2f;
    localparam logic [7:0] OFS_PIN_IRQ_MASK    = 8'h30;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned STYLE_LSB      = 6;
    localparam int unsigned CLIP_TRIG_BIT  = 0;
    localparam int unsigned FLAG_UNLOCK    = 7;
    localparam int unsigned FLAG_LOCK      = 6;
    localparam int unsigned FLAG_RAMP_UP   = 5;
    localparam int unsigned FLAG_RAMP_DOWN = 4;
    localparam int unsigned FLAG_MUTE      = 3;
    localparam int unsigned FLAG_CLIP      = 2;
    localparam int unsigned FLAG_PIN       = 1;

    // ------------------------------------------------------------------
    // writable bits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] WR_MODE_BITS  = 8'hc1;
    localparam logic [7:0] WR_MASK_BITS  = 8'hfc;
    localparam logic [7:0] WR_PIN_BITS   = 8'h7f;
    localparam logic [7:0] WR_PMASK_BITS = 8'h0f;
    localparam logic [7:0] RST_MODE      = 8'h00;
    localparam logic [7:0] RST_MASK      = 8'h00;
    localparam logic [7:0] RST_DIR       = 8'h00;
    localparam logic [7:0] RST_POL       = 8'h7f;
    localparam logic [7:0] RST_TRIG      = 8'h00;
    localparam logic [7:0] RST_PMASK     = 8'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AIP_STYLE_HIGH = 2'b00,
        AIP_STYLE_LOW  = 2'b01,
        AIP_STYLE_OD   = 2'b10,
        AIP_STYLE_RSVD = 2'b11
    } aip_style_e;

    typedef struct packed {
        logic unlock;
        logic lock;
        logic ramp_up;
        logic ramp_down;
        logic mute_done;
    } aip_events_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aip_reg_req_s;

    typedef struct packed {
        logic prev_act;
        logic sticky;
        logic out_val;
        logic drv;
        logic oe;
    } aip_pin_state_s;

    typedef struct packed {
        logic [7:0]        mode;
        logic [7:0]        mask;
        logic [7:0]        dir;
        logic [7:0]        pol;
        logic [7:0]        trig;
        logic [7:0]        pmask;
        aip_events_s       flags;
        logic [CH_CNT-1:0] clip;
        logic [7:0]        rdata;
        logic              irq_drv;
        logic              irq_oe;
    } aip_state_s;

    localparam aip_pin_state_s PIN_RST = '{default: 1'b0};

endpackage

// File: test/aip_host_model.sv
// host processor model: byte register master and watcher of the interrupt pad
// assumes read data is registered one cycle after the request edge
module aip_host_model
    import aip_pkg::*;
(
    // clock
    input  wire logic       clock_in,
    // register port
    output aip_reg_req_s    req_out,
    input  wire logic [7:0] rdata_in,
    // interrupt pad
    input  wire logic       irq_in,
    input  wire logic       irq_oe_in,
    output logic            irq_wire_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // board pull-up holds the line high when the open-drain pad lets go
    assign irq_wire_out = irq_oe_in ? irq_in : 1'b1;

    initial req_out = '0;

    task automatic access(input logic r, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clock_in);
        req_out <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge clock_in);
        req_out <= '0;
        #1 q = rdata_in;
    endtask

    // answer to an asserted pad: find the cause in the event flags
    task automatic service(output logic [7:0] q);
        access(1'b1, OFS_IRQ_EVENT_FLAGS, 8'h00, q);
    endtask
endmodule

// File: test/aip_irq_checker.sv
// checker for the interrupt and pin status block, bound to its top module
// assumes ce_in is high whenever traffic is judged
module aip_irq_checker
    import aip_pkg::*;
(
    // clock and reset
    input wire logic               clock_in,
    input wire logic               nrst_in,
    input wire logic               ce_in,
    // register port and sources
    input aip_reg_req_s            req_in,
    input wire logic [DATA_W-1:0]  rdata_out,
    input aip_events_s             events_in,
    input wire logic [CH_CNT-1:0]  clip_in,
    // pads
    input wire logic [PIN_CNT-1:0] pin_oe_out,
    input wire logic               irq_out,
    input wire logic               irq_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic [7:0] mode_q;
    logic       rd_stat;
    logic       rd_clip;

    assign rd_stat = ce_in && req_in.rd && req_in.addr == OFS_IRQ_EVENT_FLAGS;
    assign rd_clip = ce_in && req_in.rd && req_in.addr == OFS_CHANNEL_CLIP;

    // shadow of the mode register: style and clip type steer several checks
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            mode_q <= 8'h00;
        end else if (ce_in && req_in.wr && req_in.addr == OFS_IRQ_MODE_CTRL) begin
            mode_q <= req_in.wdata & WR_MODE_BITS;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_reset;
        $rose(nrst_in) |-> !irq_oe_out && pin_oe_out == '0 && rdata_out == 8'h00;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not idle after reset");

    // three quiet cycles let the registered pad catch up with a style write
    property p_style;
        $stable(mode_q) [*3] |->
            ((mode_q[7:6] == 2'b10) ? !irq_out : (irq_oe_out == !mode_q[7]));
    endproperty
    a_style: assert property (p_style)
        else $error("interrupt pad style wrong");

    property p_events;
        (events_in[2:0] != 3'b000) ##1 !rd_stat ##1 rd_stat |=>
            (rdata_out[5:3] & $past(events_in[2:0], 3)) == $past(events_in[2:0], 3);
    endproperty
    a_events: assert property (p_events)
        else $error("done flag not reported");

    property p_unlock;
        (events_in.unlock && !events_in.lock) ##1 (!rd_stat && !events_in.lock)
            ##1 (rd_stat && !events_in.lock) |=> rdata_out[7] && !rdata_out[6];
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock flag wrong");

    property p_lock;
        (events_in.lock && !events_in.unlock) ##1 (!rd_stat && !events_in.unlock)
            ##1 (rd_stat && !events_in.unlock) |=> rdata_out[6] && !rdata_out[7];
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock flag wrong");

    property p_clear;
        rd_stat ##0 (events_in == 5'h00) [*3] ##0 rd_stat |=> rdata_out[7:3] == 5'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("edge flags not cleared by read");

    property p_clip_sum;
        (clip_in != 6'h00) ##1 rd_stat |=> rdata_out[FLAG_CLIP];
    endproperty
    a_clip_sum: assert property (p_clip_sum)
        else $error("clip summary missing");

    property p_clip_chan;
        $stable(clip_in) && rd_clip |=> (rdata_out[5:0] & $past(clip_in)) == $past(clip_in);
    endproperty
    a_clip_chan: assert property (p_clip_chan)
        else $error("channel clip bit missing");

    property p_clip_level;
        (rd_clip && !mode_q[0]) ##2 rd_clip |=>
            (rdata_out[5:0] & $past(clip_in, 3)) == $past(clip_in, 3);
    endproperty
    a_clip_level: assert property (p_clip_level)
        else $error("level clip bit lost while active");

    property p_clip_edge;
        (rd_clip && mode_q[0]) ##0 (clip_in == 6'h00) [*3] ##0 rd_clip |=>
            rdata_out[5:0] == 6'h00;
    endproperty
    a_clip_edge: assert property (p_clip_edge)
        else $error("edge clip bits not cleared by read");
endmodule

bind aip_irq_ctrl aip_irq_checker i_chk (
    .clock_in (clock_in), .nrst_in (nrst_in), .ce_in (ce_in), .req_in (req_in),
    .rdata_out (rdata_out), .events_in (events_in), .clip_in (clip_in),
    .pin_oe_out (pin_oe_out), .irq_out (irq_out), .irq_oe_out (irq_oe_out)
);

// File: test/testbench.sv
// self-checking bench for the interrupt and pin status block
// assumes the host model owns the register port and the checker is bound to the top
module testbench
    import aip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals and register table
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR [9] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e,
                                       8'h30, 8'h31};
    localparam logic [7:0] RSV [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00,
                                       8'h00, 8'h00};
    localparam logic [7:0] WRM [9] = '{8'hc1, 8'hfc, 8'h00, 8'h00, 8'h7f, 8'h7f, 8'h7f,
                                       8'h0f, 8'h00};
    logic               clock_in;
    logic               nrst_in = 1'b0;
    logic               ce      = 1'b1;
    aip_reg_req_s       req;
    logic [7:0]         rdata;
    aip_events_s        ev      = '0;
    logic [CH_CNT-1:0]  clip    = '0;
    logic [PIN_CNT-1:0] pin_i   = '0;
    logic [PIN_CNT-1:0] pin_o;
    logic [PIN_CNT-1:0] pin_oe;
    logic               irq;
    logic               irq_oe;
    logic               irq_w;
    logic [7:0]         q;
    int                 mismatches  = 0;
    int                 check_count = 0;

    aip_irq_ctrl i_dut (
        .clock_in (clock_in), .nrst_in (nrst_in), .ce_in (ce), .req_in (req),
        .rdata_out (rdata), .events_in (ev), .clip_in (clip), .pin_in (pin_i),
        .pin_out (pin_o), .pin_oe_out (pin_oe), .irq_out (irq), .irq_oe_out (irq_oe)
    );
    aip_host_model i_host (
        .clock_in (clock_in), .req_out (req), .rdata_in (rdata), .irq_in (irq),
        .irq_oe_in (irq_oe), .irq_wire_out (irq_w)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_host.access(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] exp);
        i_host.access(1'b1, a, 8'h00, q);
        chk(nm, q, exp);
    endtask
    task automatic pulse(input logic [4:0] e);
        @(posedge clock_in);
        ev <= aip_events_s'(e);
        @(posedge clock_in);
        ev <= '0;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic pad(input string nm, input logic [7:0] exp);
        chk(nm, {6'h00, irq_oe, irq_w}, exp);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            rd(ADR[i], "reset value", RSV[i]);
            wr(ADR[i], 8'hff);
            rd(ADR[i], "writable bits", WRM[i]);
            wr(ADR[i], RSV[i]);
        end
    endtask
    task automatic t_events();
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            rd(OFS_IRQ_EVENT_FLAGS, "event flag", 8'h08 << i);
            rd(OFS_IRQ_EVENT_FLAGS, "flag cleared", 8'h00);
        end
        pulse(5'h10);
        pulse(5'h08);
        rd(OFS_IRQ_EVENT_FLAGS, "lock replaces unlock", 8'h40);
        pulse(5'h08);
        pulse(5'h10);
        rd(OFS_IRQ_EVENT_FLAGS, "unlock replaces lock", 8'h80);
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_SOURCE_MASK, 8'h20);
        pulse(5'h01);
        waitc(3);
        pad("masked source", 8'h02);
        pulse(5'h04);
        waitc(3);
        pad("active high", 8'h03);
        wr(OFS_IRQ_MODE_CTRL, 8'h40);
        waitc(3);
        pad("active low", 8'h02);
        wr(OFS_IRQ_MODE_CTRL, 8'h80);
        waitc(3);
        pad("open drain", 8'h02);
        i_host.service(q);
        chk("serviced flags", q, 8'h28);
        waitc(3);
        pad("released", 8'h01);
        wr(OFS_IRQ_MODE_CTRL, 8'hc0);
        waitc(3);
        pad("reserved style", 8'h01);
        wr(OFS_IRQ_MODE_CTRL, 8'h00);
        wr(OFS_IRQ_SOURCE_MASK, 8'h00);
    endtask
    task automatic t_clip();
        @(posedge clock_in);
        clip <= 6'h02;
        rd(OFS_CHANNEL_CLIP, "clip level", 8'h02);
        rd(OFS_CHANNEL_CLIP, "clip held", 8'h02);
        rd(OFS_IRQ_EVENT_FLAGS, "clip summary", 8'h04);
        rd(OFS_IRQ_EVENT_FLAGS, "summary kept", 8'h04);
        @(posedge clock_in);
        clip <= 6'h00;
        rd(OFS_CHANNEL_CLIP, "clip gone", 8'h02);
        rd(OFS_CHANNEL_CLIP, "level cleared", 8'h00);
        wr(OFS_IRQ_MODE_CTRL, 8'h01);
        @(posedge clock_in);
        clip <= 6'h21;
        @(posedge clock_in);
        clip <= 6'h00;
        rd(OFS_IRQ_EVENT_FLAGS, "edge summary", 8'h04);
        rd(OFS_CHANNEL_CLIP, "edge clip", 8'h21);
        rd(OFS_CHANNEL_CLIP, "edge cleared", 8'h00);
        rd(OFS_IRQ_EVENT_FLAGS, "summary cleared", 8'h00);
        wr(OFS_IRQ_MODE_CTRL, 8'h00);
    endtask
    task automatic t_pins();
        wr(OFS_PIN_TRIGGER, 8'h01);
        wr(OFS_PIN_IRQ_MASK, 8'h01);
        @(posedge clock_in);
        pin_i <= 7'h03;
        rd(OFS_IRQ_EVENT_FLAGS, "pin summary", 8'h02);
        rd(OFS_IRQ_EVENT_FLAGS, "pin summary kept", 8'h02);
        pad("pin raises pad", 8'h03);
        rd(OFS_PIN_STATE, "pin status", 8'h03);
        rd(OFS_PIN_STATE, "edge pin cleared", 8'h02);
        rd(OFS_IRQ_EVENT_FLAGS, "pin summary gone", 8'h00);
        wr(OFS_PIN_IRQ_MASK, 8'h02);
        rd(OFS_PIN_STATE, "level pin", 8'h02);
        rd(OFS_IRQ_EVENT_FLAGS, "level pin summary", 8'h02);
        @(posedge clock_in);
        pin_i <= 7'h00;
        wr(OFS_PIN_DIRECTION, 8'h30);
        wr(OFS_PIN_POL_TYPE, 8'h6f);
        wr(OFS_PIN_STATE, 8'h30);
        waitc(2);
        chk("drive enables", {1'b0, pin_oe}, 8'h10);
        chk("drive levels", {1'b0, pin_o}, 8'h10);
        wr(OFS_PIN_STATE, 8'h00);
        waitc(2);
        chk("open drain low", {1'b0, pin_oe}, 8'h30);
        chk("levels low", {1'b0, pin_o}, 8'h00);
        wr(OFS_PIN_DIRECTION, 8'h00);
        wr(OFS_PIN_POL_TYPE, 8'h7f);
    endtask
    // an event offered while the enable is low must leave no trace
    task automatic t_freeze();
        @(posedge clock_in);
        ce <= 1'b0;
        pulse(5'h10);
        ce <= 1'b1;
        waitc(1);
        rd(OFS_IRQ_EVENT_FLAGS, "frozen flags", 8'h00);
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    // whole run is a few hundred cycles; this bound only catches a hang
    initial begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clock_in);
        nrst_in <= 1'b1;
        t_regs();
        t_events();
        t_irq();
        t_clip();
        t_pins();
        t_freeze();
        end_sim();
    end
endmodule
